/* File: shared/rxaf_pkg.sv */
package rxaf_pkg;

	// ------------------------------------------------------------------
	// Register map (byte addresses)
	// ------------------------------------------------------------------
	localparam int              RXAF_ADDR_W         = 8;
	localparam logic [7:0]      RXAF_OFS_STA_HIGH   = 8'ha8;
	localparam logic [7:0]      RXAF_OFS_GRP_LOW    = 8'hac;
	localparam logic [7:0]      RXAF_OFS_GRP_HIGH   = 8'hb0;
	localparam logic [7:0]      RXAF_OFS_IND_LOW    = 8'hb4;
	localparam logic [7:0]      RXAF_OFS_IND_HIGH   = 8'hb8;
	localparam logic [7:0]      RXAF_OFS_MODE       = 8'hfc;

	// ------------------------------------------------------------------
	// Field positions and reset values
	// ------------------------------------------------------------------
	localparam int              RXAF_STA_FIVE_LSB   = 8;
	localparam int              RXAF_STA_FOUR_LSB   = 0;
	localparam int              RXAF_MODE_SPEED     = 31;
	localparam int              RXAF_MODE_DUPLEX    = 30;
	localparam int              RXAF_MODE_LINK      = 29;
	localparam int              RXAF_MODE_RELOAD    = 26;
	localparam int              RXAF_MODE_CFG_LSB   = 0;
	localparam logic [15:0]     RXAF_STA_RST        = 16'h0000;
	localparam logic [31:0]     RXAF_HASH_RST       = 32'h0000_0000;
	localparam logic [2:0]      RXAF_CFG_RST        = 3'h7;
	localparam logic [2:0]      RXAF_CFG_MAC_ONLY   = 3'h4;
	localparam logic [2:0]      RXAF_RX_STOPPED     = 3'h0;

	// ------------------------------------------------------------------
	// Hash constants and AXI answers
	// ------------------------------------------------------------------
	localparam logic [31:0]     RXAF_CRC_INIT       = 32'hffff_ffff;
	localparam logic [31:0]     RXAF_CRC_POLY       = 32'hedb8_8320;
	localparam logic [1:0]      RXAF_RESP_OKAY      = 2'h0;
	localparam logic [1:0]      RXAF_RESP_SLVERR    = 2'h2;

	// ------------------------------------------------------------------
	// Types
	// ------------------------------------------------------------------
	typedef struct packed {
		logic speed_100;
		logic duplex_flag;
		logic link_up;
	} rxaf_link_t;

	typedef struct packed {
		logic [7:0] station_octet_five;
		logic [7:0] station_octet_four;
	} rxaf_sta_t;

	typedef enum logic [1:0] {
		RL_IDLE = 2'b00,
		RL_BUSY = 2'b01,
		RL_BOOT = 2'b10
	} rxaf_reload_t;

	// Table bit picked by a six-bit hash index
	function automatic logic rxaf_hash_bit(input logic [31:0] lo,
		input logic [31:0] hi, input logic [5:0] idx);
		return idx[5] ? hi[idx[4:0]] : lo[idx[4:0]];
	endfunction

	// Byte-lane merge of a write into a stored word
	function automatic logic [31:0] rxaf_merge(input logic [31:0] old,
		input logic [31:0] data, input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				res[i*8 +: 8] = data[i*8 +: 8];
			end
		end
		return res;
	endfunction

endpackage

/* File: src/rxaf_hash_index.sv */
`timescale 1ns/1ps

module rxaf_hash_index
	import rxaf_pkg::*;
#(
	parameter int DA_W = 48
) (
	// Destination address, first wire octet in the low byte
	input  wire logic [DA_W-1:0] dest_addr,
	// Six low bits of the running CRC
	output logic      [5:0]      index
);

	// ------------------------------------------------------------------
	// Bit-serial CRC32, least significant bit first as on the wire
	// ------------------------------------------------------------------
	// Fully unrolled by synthesis; 48 steps is cheap next to a table
	always_comb begin
		logic [31:0] crc;
		crc = RXAF_CRC_INIT;
		for (int i = 0; i < DA_W; i++) begin
			if (crc[0] ^ dest_addr[i]) begin
				crc = (crc >> 1) ^ RXAF_CRC_POLY;
			end else begin
				crc = crc >> 1;
			end
		end
		index = crc[5:0];
	end

endmodule

/* File: src/rxaf_regs.sv */
`timescale 1ns/1ps

// How it works
// - Upper station register: octet five in 15:8, four in 7:0, rest zero.
// - Address packed little-endian; octets four and five sit in upper low bytes.
// - Station registers always readable; writes land only while receive stopped.
// - Group hash registers always readable; writes land only while receive stopped.
// - Group hash table is 64 bits, reset zero, low word bits 31:0.
// - Destination address CRC32 low six bits index the 64-entry table.
// - CRC bit five picks the word, bits four to zero pick the bit.
// - Individual hash table is 64 bits in two read-write words, reset zero.
// - Individual hash indexed exactly like the group hash.
// - Mode bit 31 reads link speed, one for 100 Mb/s, read-only.
// - Mode bit 30 reads full duplex as one, read-only.
// - Writing one to mode bit 26 reloads from EEPROM; cleared when done.
// - Mode bits 2:0 reset to 111; 100 is MAC-only, others diagnostic.
// - MAC-only mode moves an MII onto the boot ROM pins.
// - Station octets load from EEPROM automatically and stay writable.

module rxaf_regs
	import rxaf_pkg::*;
#(
	parameter int DA_W = 48
) (
	// Clock, reset, freeze
	input  wire logic                   clk,
	input  wire logic                   resetn,
	input  wire logic                   ce,
	// AXI4-Lite write address and data
	input  wire logic [RXAF_ADDR_W-1:0] s_axi_awaddr,
	input  wire logic                   s_axi_awvalid,
	output logic                        s_axi_awready,
	input  wire logic [31:0]            s_axi_wdata,
	input  wire logic [3:0]             s_axi_wstrb,
	input  wire logic                   s_axi_wvalid,
	output logic                        s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0]                  s_axi_bresp,
	output logic                        s_axi_bvalid,
	input  wire logic                   s_axi_bready,
	// AXI4-Lite read
	input  wire logic [RXAF_ADDR_W-1:0] s_axi_araddr,
	input  wire logic                   s_axi_arvalid,
	output logic                        s_axi_arready,
	output logic [31:0]                 s_axi_rdata,
	output logic [1:0]                  s_axi_rresp,
	output logic                        s_axi_rvalid,
	input  wire logic                   s_axi_rready,
	// Receive state field and link state from the MAC core
	input  wire logic [2:0]             status_register_five,
	input  wire rxaf_link_t             link_status,
	// EEPROM loader handshake
	output logic                        eeprom_reload_req,
	input  wire logic                   eeprom_load_done,
	input  wire rxaf_sta_t              eeprom_octets,
	// Destination address lookup
	input  wire logic                   rx_da_valid,
	input  wire logic [DA_W-1:0]        rx_da,
	output logic                        hash_hit_valid,
	output logic                        hash_hit,
	// Configuration toward the pin muxing
	output logic [2:0]                  operating_configuration,
	output logic                        mac_only_mii,
	output rxaf_sta_t                   station_address_high
);

	// ------------------------------------------------------------------
	// Storage
	// ------------------------------------------------------------------
	logic [31:0]            group_hash_low;
	logic [31:0]            group_hash_high;
	logic [31:0]            individual_hash_low;
	logic [31:0]            individual_hash_high;
	rxaf_link_t             link_q;
	logic                   eeprom_reload_trigger;
	rxaf_reload_t           reload_state;
	rxaf_reload_t           next_reload_state;
	logic [RXAF_ADDR_W-1:0] wr_addr;
	logic [31:0]            wr_data;
	logic [3:0]             wr_strb;
	logic [RXAF_ADDR_W-1:0] rd_addr;
	logic                   do_write;
	logic                   rd_pending;
	logic                   rx_stopped;
	logic                   reload_set;
	logic [5:0]             da_index;

	// ------------------------------------------------------------------
	// AXI4-Lite write channels
	// ------------------------------------------------------------------
	// Address and data are taken in either order; the write lands once
	// both are held and no response is outstanding
	assign do_write = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			s_axi_awready <= 1'b1;
			wr_addr       <= '0;
		end else if (ce) begin
			if (s_axi_awvalid && s_axi_awready) begin
				s_axi_awready <= 1'b0;
				wr_addr       <= s_axi_awaddr;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_awready <= 1'b1;
			end
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			s_axi_wready <= 1'b1;
			wr_data      <= '0;
			wr_strb      <= '0;
		end else if (ce) begin
			if (s_axi_wvalid && s_axi_wready) begin
				s_axi_wready <= 1'b0;
				wr_data      <= s_axi_wdata;
				wr_strb      <= s_axi_wstrb;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_wready <= 1'b1;
			end
		end
	end

	// Response; unmapped addresses answer SLVERR and store nothing
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= RXAF_RESP_OKAY;
		end else if (ce) begin
			if (do_write) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= addr_mapped(wr_addr) ? RXAF_RESP_OKAY
				                                      : RXAF_RESP_SLVERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	function automatic logic addr_mapped(input logic [RXAF_ADDR_W-1:0] a);
		return a[7:2] == RXAF_OFS_STA_HIGH[7:2] ||
		       a[7:2] == RXAF_OFS_GRP_LOW[7:2]  ||
		       a[7:2] == RXAF_OFS_GRP_HIGH[7:2] ||
		       a[7:2] == RXAF_OFS_IND_LOW[7:2]  ||
		       a[7:2] == RXAF_OFS_IND_HIGH[7:2] ||
		       a[7:2] == RXAF_OFS_MODE[7:2];
	endfunction

	function automatic logic hit(input logic [RXAF_ADDR_W-1:0] a,
		input logic [7:0] ofs);
		return do_write && a[7:2] == ofs[7:2];
	endfunction

	// ------------------------------------------------------------------
	// Station and group hash registers
	// ------------------------------------------------------------------
	assign rx_stopped = status_register_five == RXAF_RX_STOPPED;

	// EEPROM load beats a software write in the same cycle, since the
	// load is the value the hardware promised after reset or reload
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			station_address_high <= RXAF_STA_RST;
		end else if (ce) begin
			if (eeprom_load_done) begin
				station_address_high <= eeprom_octets;
			end else if (hit(wr_addr, RXAF_OFS_STA_HIGH) && rx_stopped) begin
				station_address_high <= 16'(rxaf_merge(
					{16'h0000, station_address_high}, wr_data,
					wr_strb));
			end
		end
	end

	// Group table only changes while receive is stopped
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			group_hash_low  <= RXAF_HASH_RST;
			group_hash_high <= RXAF_HASH_RST;
		end else if (ce && rx_stopped) begin
			if (hit(wr_addr, RXAF_OFS_GRP_LOW)) begin
				group_hash_low <= rxaf_merge(group_hash_low, wr_data,
					wr_strb);
			end
			if (hit(wr_addr, RXAF_OFS_GRP_HIGH)) begin
				group_hash_high <= rxaf_merge(group_hash_high, wr_data,
					wr_strb);
			end
		end
	end

	// Individual table carries no receive-state gate
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			individual_hash_low  <= RXAF_HASH_RST;
			individual_hash_high <= RXAF_HASH_RST;
		end else if (ce) begin
			if (hit(wr_addr, RXAF_OFS_IND_LOW)) begin
				individual_hash_low <= rxaf_merge(individual_hash_low,
					wr_data, wr_strb);
			end
			if (hit(wr_addr, RXAF_OFS_IND_HIGH)) begin
				individual_hash_high <= rxaf_merge(individual_hash_high,
					wr_data, wr_strb);
			end
		end
	end

	// ------------------------------------------------------------------
	// Mode register
	// ------------------------------------------------------------------
	// Link inputs sampled so a read sees one coherent snapshot
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			link_q <= '0;
		end else if (ce) begin
			link_q <= link_status;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			operating_configuration <= RXAF_CFG_RST;
			mac_only_mii            <= 1'b0;
		end else if (ce) begin
			if (hit(wr_addr, RXAF_OFS_MODE) && wr_strb[0]) begin
				operating_configuration <= wr_data[RXAF_MODE_CFG_LSB +: 3];
			end
			mac_only_mii <= operating_configuration
			                == RXAF_CFG_MAC_ONLY;
		end
	end

	assign reload_set = hit(wr_addr, RXAF_OFS_MODE) && wr_strb[3] &&
	                    wr_data[RXAF_MODE_RELOAD];

	// A fresh write of one wins over the completion that would clear it
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			eeprom_reload_trigger <= 1'b0;
		end else if (ce) begin
			if (reload_set) begin
				eeprom_reload_trigger <= 1'b1;
			end else if (reload_state == RL_BUSY && eeprom_load_done) begin
				eeprom_reload_trigger <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------------
	// Reload sequencer: boot load after reset, then on demand
	// ------------------------------------------------------------------
	always_comb begin
		next_reload_state = reload_state;
		unique case (reload_state)
			// A bit 26 write during the boot load earns its own reload,
			// otherwise the bit would never see a completion to clear it
			RL_BOOT: begin
				if (eeprom_load_done) begin
					next_reload_state = (reload_set || eeprom_reload_trigger)
					                    ? RL_BUSY : RL_IDLE;
				end
			end
			RL_BUSY: begin
				if (eeprom_load_done && !reload_set) begin
					next_reload_state = RL_IDLE;
				end
			end
			RL_IDLE: begin
				if (reload_set) begin
					next_reload_state = RL_BUSY;
				end
			end
			default: begin
				next_reload_state = RL_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			reload_state      <= RL_BOOT;
			eeprom_reload_req <= 1'b0;
		end else if (ce) begin
			reload_state      <= next_reload_state;
			eeprom_reload_req <= next_reload_state != RL_IDLE;
		end
	end

	// ------------------------------------------------------------------
	// AXI4-Lite read channel, two cycles from address to data
	// ------------------------------------------------------------------
	assign rd_pending = !s_axi_arready && !s_axi_rvalid;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= '0;
			s_axi_rresp   <= RXAF_RESP_OKAY;
			rd_addr       <= '0;
		end else if (ce) begin
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_arready <= 1'b0;
				rd_addr       <= s_axi_araddr;
			end else if (rd_pending) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp  <= addr_mapped(rd_addr) ? RXAF_RESP_OKAY
				                                      : RXAF_RESP_SLVERR;
				unique case (rd_addr[7:2])
					RXAF_OFS_STA_HIGH[7:2]: s_axi_rdata <=
						{16'h0000, station_address_high};
					RXAF_OFS_GRP_LOW[7:2]:  s_axi_rdata <= group_hash_low;
					RXAF_OFS_GRP_HIGH[7:2]: s_axi_rdata <= group_hash_high;
					RXAF_OFS_IND_LOW[7:2]:  s_axi_rdata <= individual_hash_low;
					RXAF_OFS_IND_HIGH[7:2]: s_axi_rdata <= individual_hash_high;
					RXAF_OFS_MODE[7:2]:     s_axi_rdata <=
						{link_q, 2'b00, eeprom_reload_trigger, 23'h0,
						 operating_configuration};
					default:                s_axi_rdata <= 32'h0000_0000;
				endcase
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid  <= 1'b0;
				s_axi_arready <= 1'b1;
			end
		end
	end

	// ------------------------------------------------------------------
	// Hash filter lookup
	// ------------------------------------------------------------------
	rxaf_hash_index #(
		.DA_W      (DA_W)
	) u_hash_index (
		.dest_addr (rx_da),
		.index     (da_index)
	);

	// Group bit of the first octet picks the table, one cycle latency
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			hash_hit_valid <= 1'b0;
			hash_hit       <= 1'b0;
		end else if (ce) begin
			hash_hit_valid <= rx_da_valid;
			if (rx_da_valid) begin
				hash_hit <= rx_da[0]
					? rxaf_hash_bit(group_hash_low, group_hash_high,
					                da_index)
					: rxaf_hash_bit(individual_hash_low,
					                individual_hash_high,
					                da_index);
			end
		end
	end

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!resetn);

	sequence wr_stopped(logic [7:0] ofs);
		ce && hit(wr_addr, ofs) && rx_stopped && !eeprom_load_done;
	endsequence

	sequence wr_running;
		ce && do_write && !rx_stopped && !eeprom_load_done;
	endsequence

	sta_write_a: assert property (wr_stopped(RXAF_OFS_STA_HIGH) ##0
		wr_strb[1] |=> station_address_high.station_octet_five ==
		$past(wr_data[15:8]))
		else $error("station octet five not written");

	grp_write_a: assert property (wr_stopped(RXAF_OFS_GRP_LOW) ##0
		(wr_strb == 4'hf) |=> group_hash_low == $past(wr_data))
		else $error("group hash low not written");

	running_hold_a: assert property (wr_running |=> $stable(group_hash_low)
		&& $stable(group_hash_high) && $stable(station_address_high))
		else $error("address register changed while receiving");

	boot_load_a: assert property (ce && eeprom_load_done |=>
		station_address_high == $past(eeprom_octets))
		else $error("eeprom octets not loaded");

	reload_clear_a: assert property (ce && reload_state == RL_BUSY &&
		eeprom_load_done && !reload_set |=> !eeprom_reload_trigger
		##0 !eeprom_reload_req)
		else $error("reload bit not cleared on completion");

	reload_start_a: assert property (ce && reload_set |=>
		eeprom_reload_trigger && eeprom_reload_req)
		else $error("reload write did not start a reload");

	hash_hit_a: assert property (ce && rx_da_valid |=> hash_hit_valid &&
		hash_hit == $past(rx_da[0] ? (da_index[5]
			? group_hash_high[da_index[4:0]]
			: group_hash_low[da_index[4:0]])
		: (da_index[5] ? individual_hash_high[da_index[4:0]]
			: individual_hash_low[da_index[4:0]])))
		else $error("hash filter result wrong");

	mac_only_a: assert property (ce |=> mac_only_mii ==
		($past(operating_configuration) == RXAF_CFG_MAC_ONLY))
		else $error("mac-only pin select wrong");

	mode_read_a: assert property ($rose(s_axi_rvalid) &&
		rd_addr[7:2] == RXAF_OFS_MODE[7:2] |-> s_axi_rdata[31:29] ==
		$past(link_q) && s_axi_rdata[2:0] ==
		$past(operating_configuration))
		else $error("mode register read wrong");

	read_lat_a: assert property (ce && s_axi_arvalid && s_axi_arready
		##1 ce |=> s_axi_rvalid)
		else $error("read answer late");

endmodule

/* File: test/rx_address_filter_regs_test.sv */
`timescale 1ns/1ps

module rx_address_filter_regs_test
	import rxaf_pkg::*;
;
	// ------------------------------------------------------------
	// Signals and unit
	// ------------------------------------------------------------
	logic                   clk, resetn, ce;
	logic [RXAF_ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0]            s_axi_wdata, s_axi_rdata;
	logic [3:0]             s_axi_wstrb;
	logic [1:0]             s_axi_bresp, s_axi_rresp;
	logic                   s_axi_awvalid, s_axi_awready, s_axi_wvalid;
	logic                   s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic                   s_axi_arvalid, s_axi_arready, s_axi_rvalid;
	logic                   s_axi_rready, eeprom_reload_req, eeprom_load_done;
	logic [2:0]             status_register_five, operating_configuration;
	rxaf_link_t             link_status;
	rxaf_sta_t              eeprom_octets, station_address_high;
	logic                   rx_da_valid, hash_hit_valid, hash_hit;
	logic                   mac_only_mii;
	logic [47:0]            rx_da;
	int                     err_total, n_tests;

	rxaf_regs #(.DA_W(48)) uut (.clk, .resetn, .ce, .s_axi_awaddr,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.status_register_five, .link_status, .eeprom_reload_req,
		.eeprom_load_done, .eeprom_octets, .rx_da_valid, .rx_da,
		.hash_hit_valid, .hash_hit, .operating_configuration,
		.mac_only_mii, .station_address_high);

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	// Verdict and the single end of the run
	task automatic conclude();
		$display("tests %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, exp, input string m);
		n_tests++;
		if (got !== exp) begin
			err_total++;
			$display("BAD %0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask

	// Every wait is bounded; a hang ends the run as a mismatch
	task automatic guard(inout int n);
		n++;
		if (n > 50) begin
			err_total++;
			$display("BAD %0t wait timed out", $time);
			conclude();
		end
	endtask

	// AXI write: AW and W offered together, each dropped when taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] s, output logic [1:0] r);
		int n;
		bit aw_ok, w_ok;
		n = 0;
		aw_ok = 0;
		w_ok = 0;
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_awvalid <= 1'b1;
		s_axi_wdata <= d;
		s_axi_wstrb <= s;
		s_axi_wvalid <= 1'b1;
		while (!(aw_ok && w_ok)) begin
			@(posedge clk);
			guard(n);
			if (s_axi_awvalid && s_axi_awready === 1'b1) begin
				aw_ok = 1;
				s_axi_awvalid <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready === 1'b1) begin
				w_ok = 1;
				s_axi_wvalid <= 1'b0;
			end
		end
		s_axi_bready <= 1'b1;
		do begin
			@(posedge clk);
			guard(n);
		end while (s_axi_bvalid !== 1'b1);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d,
		output logic [1:0] r);
		int n;
		n = 0;
		@(posedge clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do begin
			@(posedge clk);
			guard(n);
		end while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge clk);
			guard(n);
		end while (s_axi_rvalid !== 1'b1);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask

	// Mapped accesses must answer OKAY
	task automatic w(input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] s = 4'hf);
		logic [1:0] r;
		wr(a, d, s, r);
		chk(32'(r), 32'(RXAF_RESP_OKAY), "bresp");
	endtask

	task automatic rc(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] d;
		logic [1:0]  r;
		rd(a, d, r);
		chk(32'(r), 32'(RXAF_RESP_OKAY), "rresp");
		chk(d, e, "read");
	endtask

	// Loader finish pulse carrying the octets
	task automatic ld(input rxaf_sta_t o);
		@(posedge clk);
		eeprom_octets <= o;
		eeprom_load_done <= 1'b1;
		@(posedge clk);
		eeprom_load_done <= 1'b0;
		repeat (2) @(posedge clk);
	endtask

	task automatic look(input logic [47:0] da, input logic e);
		@(posedge clk);
		rx_da <= da;
		rx_da_valid <= 1'b1;
		@(posedge clk);
		rx_da_valid <= 1'b0;
		@(posedge clk);
		chk(32'(hash_hit_valid), 32'h1, "hit valid");
		chk(32'(hash_hit), 32'(e), "hit");
	endtask

	// Own CRC, lsb first, no final complement
	function automatic logic [5:0] crc_idx(input logic [47:0] da);
		logic [31:0] c;
		c = RXAF_CRC_INIT;
		for (int i = 0; i < 48; i++) begin
			c = (c[0] ^ da[i]) ? (c >> 1) ^ RXAF_CRC_POLY : c >> 1;
		end
		return c[5:0];
	endfunction

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_boot();
		chk(32'(operating_configuration), 32'h7, "cfg");
		for (int i = 0; i < 4; i++) begin
			rc(RXAF_OFS_GRP_LOW + 8'(4 * i), 32'h0);
		end
		chk(32'(eeprom_reload_req), 32'h1, "boot req");
		ld(16'h3322);
		chk(32'(eeprom_reload_req), 32'h0, "req drop");
		chk(32'(station_address_high), 32'h3322, "sta");
		rc(RXAF_OFS_STA_HIGH, 32'h0000_3322);
		rc(RXAF_OFS_MODE, 32'h0000_0007);
		$display("boot done");
	endtask

	// Writes while receive runs, then stopped, with partial lanes
	task automatic t_gate();
		@(posedge clk);
		status_register_five <= 3'h2;
		w(RXAF_OFS_STA_HIGH, 32'h0000_5566);
		w(RXAF_OFS_GRP_LOW, 32'hffff_ffff);
		w(RXAF_OFS_IND_LOW, 32'h1234_5678);
		rc(RXAF_OFS_STA_HIGH, 32'h0000_3322);
		rc(RXAF_OFS_GRP_LOW, 32'h0);
		rc(RXAF_OFS_IND_LOW, 32'h1234_5678);
		status_register_five <= RXAF_RX_STOPPED;
		w(RXAF_OFS_STA_HIGH, 32'hffff_5566);
		rc(RXAF_OFS_STA_HIGH, 32'h0000_5566);
		chk(32'(station_address_high), 32'h5566, "sta");
		w(RXAF_OFS_GRP_HIGH, 32'ha1b2_c3d4, 4'h5);
		rc(RXAF_OFS_GRP_HIGH, 32'h00b2_00d4);
		w(RXAF_OFS_GRP_HIGH, 32'h0);
		w(RXAF_OFS_IND_LOW, 32'h0);
		$display("gate done");
	endtask

	task automatic t_unmapped();
		logic [31:0] d;
		logic [1:0]  r;
		wr(8'hc0, 32'hffff_ffff, 4'hf, r);
		chk(32'(r), 32'(RXAF_RESP_SLVERR), "bad bresp");
		rd(8'hc0, d, r);
		chk(32'(r), 32'(RXAF_RESP_SLVERR), "bad rresp");
		chk(d, 32'h0, "bad rdata");
		$display("unmapped done");
	endtask

	task automatic t_mode();
		@(posedge clk);
		link_status <= 3'b101;
		rc(RXAF_OFS_MODE, 32'ha000_0007);
		link_status <= 3'b010;
		rc(RXAF_OFS_MODE, 32'h4000_0007);
		w(RXAF_OFS_MODE, 32'he000_0004);
		rc(RXAF_OFS_MODE, 32'h4000_0004);
		chk(32'(operating_configuration), 32'h4, "cfg");
		chk(32'(mac_only_mii), 32'h1, "mii");
		w(RXAF_OFS_MODE, 32'h7);
		repeat (2) @(posedge clk);
		chk(32'(mac_only_mii), 32'h0, "mii off");
		link_status <= 3'b000;
		w(RXAF_OFS_MODE, 32'h0400_0007);
		rc(RXAF_OFS_MODE, 32'h0400_0007);
		chk(32'(eeprom_reload_req), 32'h1, "reload req");
		ld(16'h7788);
		rc(RXAF_OFS_MODE, 32'h0000_0007);
		rc(RXAF_OFS_STA_HIGH, 32'h0000_7788);
		// Frozen by the enable, a loader pulse must leave no trace
		ce <= 1'b0;
		ld(16'h9999);
		ce <= 1'b1;
		rc(RXAF_OFS_STA_HIGH, 32'h0000_7788);
		$display("mode done");
	endtask

	// Set the hashed bit, then its neighbours, other word, other table
	task automatic t_lookup();
		logic [47:0] da;
		logic [5:0]  idx;
		logic [7:0]  a, b, o;
		logic [31:0] m;
		for (int i = 0; i < 2; i++) begin
			da = 48'h3322_11e8_0000 | 48'(1 - i);
			idx = crc_idx(da);
			a = i == 0 ? RXAF_OFS_GRP_LOW : RXAF_OFS_IND_LOW;
			b = i == 0 ? RXAF_OFS_IND_LOW : RXAF_OFS_GRP_LOW;
			o = a + 8'(4 * !idx[5]);
			a = a + 8'(4 * idx[5]);
			b = b + 8'(4 * idx[5]);
			m = 32'h1 << idx[4:0];
			w(a, m);
			look(da, 1'b1);
			w(a, ~m);
			look(da, 1'b0);
			w(a, 32'h0);
			w(o, m);
			look(da, 1'b0);
			w(o, 32'h0);
			w(b, m);
			look(da, 1'b0);
			w(b, 32'h0);
		end
		$display("lookup done");
	endtask

	// ------------------------------------------------------------
	// Clock, reset and sequence
	// ------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	initial begin
		err_total = 0;
		n_tests = 0;
		resetn = 1'b0;
		ce = 1'b1;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
		{s_axi_arvalid, s_axi_rready, eeprom_load_done} = '0;
		status_register_five = RXAF_RX_STOPPED;
		link_status = '0;
		eeprom_octets = '0;
		rx_da_valid = 1'b0;
		rx_da = '0;
		repeat (10) @(posedge clk);
		resetn <= 1'b1;
		t_boot();
		t_gate();
		t_unmapped();
		t_mode();
		t_lookup();
		conclude();
	end
endmodule
